// ### inc/wptw_pkg.sv
// Shared constants and types of the wake pattern and watchdog block
package wptw_pkg;
   localparam int unsigned CLK_NS         = 10;
   // Register byte offsets
   localparam logic [7:0]  ADR_PATTERN    = 8'h70;
   localparam logic [7:0]  ADR_MATCH_EN   = 8'h74;
   localparam logic [7:0]  ADR_WDT        = 8'h78;
   localparam logic [7:0]  ADR_STATUS     = 8'h7C;
   localparam logic [7:0]  ADR_IRQ_CLR    = 8'h80;
   localparam logic [7:0]  ADR_IRQ_EN     = 8'h84;
   // Watchdog control register
   localparam logic [31:0] WDT_RST        = 32'h0000_0000;
   localparam logic [31:0] WDT_RW         = 32'h1000_0037;
   localparam int unsigned BIT_RXCK_INV   = 28;
   localparam int unsigned BIT_RW_REL     = 5;
   localparam int unsigned BIT_RW_DIS     = 4;
   localparam int unsigned BIT_JAB_SEL    = 2;
   localparam int unsigned BIT_NO_REEN    = 1;
   localparam int unsigned BIT_JAB_DIS    = 0;
   // Pattern table
   localparam int unsigned NUM_PAT        = 5;
   localparam int unsigned WPP            = 5;
   localparam int unsigned NUM_WORDS      = 25;
   localparam int unsigned IDX_W          = 5;
   localparam logic [4:0]  IDX_LAST       = 5'h18;
   localparam int unsigned CRC_LSB        = 16;
   localparam int unsigned OFS_LSB        = 0;
   localparam int unsigned OFS_W          = 8;
   localparam logic [15:0] CRC_INIT       = 16'hFFFF;
   localparam logic [15:0] CRC_POLY       = 16'h8005;
   localparam logic [3:0]  SFD_NIB        = 4'hD;
   localparam logic [8:0]  POS_MAX        = 9'h1FF;
   localparam logic [8:0]  MASK_SPAN      = 9'h080;
   localparam logic [7:0]  MATCH_EN_RST   = 8'h00;
   // Status, clear and enable layout
   localparam int unsigned ST_W           = 3;
   localparam int unsigned ST_WAKE        = 0;
   localparam int unsigned ST_RX_WDT      = 1;
   localparam int unsigned ST_JAB         = 2;
   localparam int unsigned IDX_LSB        = 8;
   // Receive watchdog
   localparam int unsigned RX_MAX_BYTES   = 2560;
   localparam int unsigned REL_SHORT_BITS = 24;
   localparam int unsigned REL_LONG_BITS  = 48;
   localparam int unsigned NIB_BITS       = 4;
   localparam int unsigned REL_SHORT_NIB  = REL_SHORT_BITS / NIB_BITS;
   localparam int unsigned REL_LONG_NIB   = REL_LONG_BITS / NIB_BITS;
   // Transmit jabber
   localparam int unsigned JAB_100_US     = 2600;
   localparam int unsigned JAB_10_US      = 26000;
   localparam int unsigned REEN_US        = 42000;
   localparam int unsigned JAB_BYTES      = 2560;
   localparam int unsigned BYTE_NS_100    = 80;
   localparam int unsigned BYTE_NS_10     = 800;
   localparam int unsigned JAB_100_CYC    = JAB_100_US * 1000 / CLK_NS;
   localparam int unsigned JAB_10_CYC     = JAB_10_US * 1000 / CLK_NS;
   localparam int unsigned REEN_CYC       = REEN_US * 1000 / CLK_NS;
   localparam int unsigned BYTE_CYC_100   = BYTE_NS_100 / CLK_NS;
   localparam int unsigned BYTE_CYC_10    = BYTE_NS_10 / CLK_NS;
   localparam int unsigned JAB_BT_100_CYC = JAB_BYTES * BYTE_CYC_100;
   localparam int unsigned JAB_BT_10_CYC  = JAB_BYTES * BYTE_CYC_10;
   localparam int unsigned TMR_W          = 23;

   typedef enum logic [1:0] {RX_IDLE, RX_HUNT, RX_DATA} wptw_rx_t;
   typedef enum logic [1:0] {JB_IDLE, JB_RUN, JB_CUT} wptw_jab_t;
endpackage

// ### inc/wptw_tmr_if.sv
// Control and done signals between supervision logic and a timer
`timescale 1ns/1ps
interface wptw_tmr_if #(parameter int unsigned W = 23);
   logic         clr;
   logic         run;
   logic [W-1:0] limit;
   logic         done;
   modport ctl (output clr, output run, output limit, input done);
   modport tmr (input clr, input run, input limit, output done);
endinterface

// ### design/wptw_timer.sv
// Saturating up counter with clear, run and limit compare
`timescale 1ns/1ps
module wptw_timer #(
   parameter int unsigned W = 23
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   wptw_tmr_if.tmr   t
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;

   always_comb begin
      cnt_d = cnt_q;
      if (t.clr) begin
         cnt_d = '0;
      end else if (t.run && !t.done) begin
         cnt_d = cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign t.done = (cnt_q >= t.limit);
endmodule // wptw_timer

// ### design/wptw_top.sv
// Wake pattern table loader, rx watchdog and tx jabber supervisor
`timescale 1ns/1ps
module wptw_top
   import wptw_pkg::*;
#(
   parameter int unsigned JAB_100_CYCLES    = JAB_100_CYC,
   parameter int unsigned JAB_10_CYCLES     = JAB_10_CYC,
   parameter int unsigned REEN_CYCLES       = REEN_CYC,
   parameter int unsigned JAB_BT_100_CYCLES = JAB_BT_100_CYC,
   parameter int unsigned JAB_BT_10_CYCLES  = JAB_BT_10_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic             wb_ack_o,
   input  wire logic        mii_rx_clk_i,
   input  wire logic        mii_rx_dv_i,
   input  wire logic [3:0]  mii_rxd_i,
   input  wire logic        tx_en_i,
   input  wire logic        speed_100_i,
   output logic             tx_cutoff_o,
   output logic             rx_wdt_expired_o,
   output logic             irq_o
);
   // Register file state
   logic [31:0]      pat_q [NUM_WORDS];
   logic [31:0]      pat_d [NUM_WORDS];
   logic [IDX_W-1:0] idx_q, idx_d;
   logic [31:0]      wdt_q, wdt_d;
   logic [7:0]       men_q, men_d;
   logic [ST_W-1:0]  st_q, st_d;
   logic [ST_W-1:0]  ien_q, ien_d;
   logic             ack_q, ack_d;
   logic [31:0]      dat_q, dat_d;
   logic             irq_q, irq_d;
   logic             acc;
   logic [7:0]       adr;
   logic [31:0]      bmask;
   logic [ST_W-1:0]  ev;
   // Control bits
   logic             rx_clock_invert;
   logic             rx_watchdog_release_sel;
   logic             rx_watchdog_disable;
   logic             jabber_time_sel;
   logic             no_auto_tx_reenable;
   logic             jabber_disable;
   // Per pattern views of the table
   logic [127:0]     pmask [NUM_PAT];
   logic [15:0]      pcrc  [NUM_PAT];
   logic [OFS_W-1:0] pofs  [NUM_PAT];
   // Receive side
   logic [2:0]       ck_s;
   logic [1:0]       dv_s;
   logic [3:0]       d_s1, d_s2;
   logic             nib;
   wptw_rx_t         rx_q, rx_d;
   logic             half_q, half_d;
   logic [3:0]       lo_q, lo_d;
   logic [8:0]       pos_q, pos_d;
   logic [15:0]      crc_q [NUM_PAT];
   logic [15:0]      crc_d [NUM_PAT];
   logic             rwx_q, rwx_d;
   logic             bstb;
   logic [7:0]       byte_v;
   logic [8:0]       k;
   logic             wake_ev, rxw_ev;
   // Transmit side
   wptw_jab_t        jb_q, jb_d;
   logic             cut_q, cut_d;
   logic [TMR_W-1:0] jlim;
   logic             jab_ev;

   wptw_tmr_if #(.W(TMR_W)) bt_if ();
   wptw_tmr_if #(.W(TMR_W)) rel_if ();
   wptw_tmr_if #(.W(TMR_W)) jt_if ();

   wptw_timer #(.W(TMR_W)) u_byte_tmr (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .t     (bt_if)
   );
   wptw_timer #(.W(TMR_W)) u_rel_tmr (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .t     (rel_if)
   );
   wptw_timer #(.W(TMR_W)) u_jab_tmr (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .t     (jt_if)
   );

   function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                            input logic [7:0]  b);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         if (r[15] ^ b[i]) begin
            r = {r[14:0], 1'b0} ^ CRC_POLY;
         end else begin
            r = {r[14:0], 1'b0};
         end
      end
      return r;
   endfunction

   assign rx_clock_invert         = wdt_q[BIT_RXCK_INV];
   assign rx_watchdog_release_sel = wdt_q[BIT_RW_REL];
   assign rx_watchdog_disable     = wdt_q[BIT_RW_DIS];
   assign jabber_time_sel         = wdt_q[BIT_JAB_SEL];
   assign no_auto_tx_reenable     = wdt_q[BIT_NO_REEN];
   assign jabber_disable          = wdt_q[BIT_JAB_DIS];

   for (genvar p = 0; p < NUM_PAT; p++) begin : g_pat
      assign pmask[p] = {pat_q[p*WPP+3], pat_q[p*WPP+2],
                         pat_q[p*WPP+1], pat_q[p*WPP]};
      assign pcrc[p]  = pat_q[p*WPP+4][CRC_LSB +: 16];
      assign pofs[p]  = pat_q[p*WPP+4][OFS_LSB +: OFS_W];
   end

   // Wishbone slave and registers
   always_comb begin
      acc   = wb_cyc_i & wb_stb_i & ~ack_q;
      adr   = {wb_adr_i[7:2], 2'b00};
      bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
               {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      pat_d = pat_q;
      idx_d = idx_q;
      wdt_d = wdt_q;
      men_d = men_q;
      ien_d = ien_q;
      st_d  = st_q;
      ack_d = acc;
      dat_d = '0;
      if (acc && wb_we_i) begin
         case (adr)
            ADR_PATTERN: begin
               pat_d[idx_q] = (pat_q[idx_q] & ~bmask)
                            | (wb_dat_i & bmask);
               idx_d = (idx_q == IDX_LAST) ? '0
                                           : idx_q + 1'b1;
            end
            ADR_WDT: begin
               wdt_d = (wdt_q & ~(bmask & WDT_RW))
                     | (wb_dat_i & bmask & WDT_RW);
            end
            ADR_MATCH_EN: begin
               if (wb_sel_i[0]) begin
                  men_d = {3'b000, wb_dat_i[NUM_PAT-1:0]};
               end
            end
            ADR_IRQ_EN: begin
               if (wb_sel_i[0]) begin
                  ien_d = wb_dat_i[ST_W-1:0];
               end
            end
            ADR_IRQ_CLR: begin
               if (wb_sel_i[0]) begin
                  st_d = st_q & ~wb_dat_i[ST_W-1:0];
               end
            end
            default: ;
         endcase
      end else if (acc) begin
         case (adr)
            ADR_WDT:      dat_d = wdt_q;
            ADR_MATCH_EN: dat_d = {24'h00_0000, men_q};
            ADR_IRQ_EN:   dat_d[ST_W-1:0] = ien_q;
            ADR_STATUS: begin
               dat_d[ST_W-1:0]         = st_q;
               dat_d[IDX_LSB +: IDX_W] = idx_q;
            end
            default:      dat_d = '0;
         endcase
      end
      // Set wins over a clear in the same cycle
      st_d  = st_d | ev;
      irq_d = |(st_q & ien_q);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < NUM_WORDS; i++) begin
            pat_q[i] <= '0;
         end
         idx_q <= '0;
         wdt_q <= WDT_RST;
         men_q <= MATCH_EN_RST;
         ien_q <= '0;
         st_q  <= '0;
         ack_q <= 1'b0;
         dat_q <= '0;
         irq_q <= 1'b0;
      end else begin
         pat_q <= pat_d;
         idx_q <= idx_d;
         wdt_q <= wdt_d;
         men_q <= men_d;
         ien_q <= ien_d;
         st_q  <= st_d;
         ack_q <= ack_d;
         dat_q <= dat_d;
         irq_q <= irq_d;
      end
   end

   assign ev[ST_WAKE]   = wake_ev;
   assign ev[ST_RX_WDT] = rxw_ev;
   assign ev[ST_JAB]    = jab_ev;

   // MII pins pass two flip-flops; third clock stage is for edges
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ck_s <= '0;
         dv_s <= '0;
         d_s1 <= '0;
         d_s2 <= '0;
      end else begin
         ck_s <= {ck_s[1:0], mii_rx_clk_i};
         dv_s <= {dv_s[0], mii_rx_dv_i};
         d_s1 <= mii_rxd_i;
         d_s2 <= d_s1;
      end
   end

   assign nib = rx_clock_invert ? (~ck_s[1] & ck_s[2])
                                : (ck_s[1] & ~ck_s[2]);

   // Receive frame tracking, pattern CRCs and watchdog
   always_comb begin
      rx_d    = rx_q;
      half_d  = half_q;
      lo_d    = lo_q;
      pos_d   = pos_q;
      crc_d   = crc_q;
      rwx_d   = rwx_q;
      bstb    = 1'b0;
      wake_ev = 1'b0;
      rxw_ev  = 1'b0;
      k       = '0;
      byte_v  = {d_s2, lo_q};
      if (nib) begin
         unique case (rx_q)
            RX_IDLE: begin
               if (dv_s[1]) begin
                  rx_d = RX_HUNT;
               end
            end
            RX_HUNT: begin
               if (!dv_s[1]) begin
                  rx_d = RX_IDLE;
               end else if (d_s2 == SFD_NIB) begin
                  rx_d   = RX_DATA;
                  half_d = 1'b0;
                  pos_d  = '0;
                  for (int p = 0; p < NUM_PAT; p++) begin
                     crc_d[p] = CRC_INIT;
                  end
               end
            end
            RX_DATA: begin
               if (!dv_s[1]) begin
                  rx_d = RX_IDLE;
                  for (int p = 0; p < NUM_PAT; p++) begin
                     if (men_q[p] && !rwx_q
                         && crc_q[p] == pcrc[p]) begin
                        wake_ev = 1'b1;
                     end
                  end
               end else begin
                  half_d = ~half_q;
                  lo_d   = d_s2;
                  if (half_q) begin
                     bstb  = 1'b1;
                     pos_d = (pos_q == POS_MAX) ? pos_q
                                                : pos_q + 1'b1;
                     for (int p = 0; p < NUM_PAT; p++) begin
                        k = pos_q - {1'b0, pofs[p]};
                        if (pos_q >= {1'b0, pofs[p]} && k < MASK_SPAN
                            && pmask[p][k[6:0]]) begin
                           crc_d[p] = crc_byte(crc_q[p], byte_v);
                        end
                     end
                  end
               end
            end
         endcase
      end
      if (bt_if.done && !rx_watchdog_disable && !rwx_q
          && rx_q == RX_DATA) begin
         rwx_d  = 1'b1;
         rxw_ev = 1'b1;
      end else if (rwx_q && rel_if.done) begin
         rwx_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_q   <= RX_IDLE;
         half_q <= 1'b0;
         lo_q   <= '0;
         pos_q  <= '0;
         for (int p = 0; p < NUM_PAT; p++) begin
            crc_q[p] <= '0;
         end
         rwx_q  <= 1'b0;
      end else begin
         rx_q   <= rx_d;
         half_q <= half_d;
         lo_q   <= lo_d;
         pos_q  <= pos_d;
         crc_q  <= crc_d;
         rwx_q  <= rwx_d;
      end
   end

   assign bt_if.clr    = (rx_q != RX_DATA);
   assign bt_if.run    = bstb;
   assign bt_if.limit  = TMR_W'(RX_MAX_BYTES + 1);
   assign rel_if.clr   = dv_s[1];
   assign rel_if.run   = nib;
   assign rel_if.limit = rx_watchdog_release_sel
                         ? TMR_W'(REL_LONG_NIB)
                         : TMR_W'(REL_SHORT_NIB);

   // Transmit jabber supervision
   always_comb begin
      jb_d   = jb_q;
      jab_ev = 1'b0;
      unique case (jb_q)
         JB_IDLE: begin
            if (tx_en_i && !jabber_disable) begin
               jb_d = JB_RUN;
            end
         end
         JB_RUN: begin
            if (!tx_en_i || jabber_disable) begin
               jb_d = JB_IDLE;
            end else if (jt_if.done) begin
               jb_d   = JB_CUT;
               jab_ev = 1'b1;
            end
         end
         JB_CUT: begin
            if (jabber_disable) begin
               jb_d = JB_IDLE;
            end else if (no_auto_tx_reenable) begin
               if (!tx_en_i) begin
                  jb_d = JB_IDLE;
               end
            end else if (jt_if.done) begin
               jb_d = JB_IDLE;
            end
         end
      endcase
      if (jb_q == JB_CUT) begin
         jlim = TMR_W'(REEN_CYCLES);
      end else if (jabber_time_sel) begin
         jlim = speed_100_i ? TMR_W'(JAB_BT_100_CYCLES)
                            : TMR_W'(JAB_BT_10_CYCLES);
      end else begin
         jlim = speed_100_i ? TMR_W'(JAB_100_CYCLES)
                            : TMR_W'(JAB_10_CYCLES);
      end
      cut_d = (jb_d == JB_CUT);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         jb_q  <= JB_IDLE;
         cut_q <= 1'b0;
      end else begin
         jb_q  <= jb_d;
         cut_q <= cut_d;
      end
   end

   assign jt_if.clr   = (jb_q == JB_IDLE) || (jb_d != jb_q);
   assign jt_if.run   = 1'b1;
   assign jt_if.limit = jlim;

   assign wb_dat_o         = dat_q;
   assign wb_ack_o         = ack_q;
   assign irq_o            = irq_q;
   assign tx_cutoff_o      = cut_q;
   assign rx_wdt_expired_o = rwx_q;
endmodule // wptw_top

// ### bench/wptw_properties.sv
// Port-level checks of the wake pattern and watchdog block
`timescale 1ns/1ps
module wptw_properties
   import wptw_pkg::*;
#(
   parameter int unsigned JAB_100_CYCLES    = 50,
   parameter int unsigned JAB_10_CYCLES     = 100,
   parameter int unsigned REEN_CYCLES       = 80,
   parameter int unsigned JAB_BT_100_CYCLES = 40,
   parameter int unsigned JAB_BT_10_CYCLES  = 60
) (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_we_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic        mii_rx_clk_i,
   input wire logic        mii_rx_dv_i,
   input wire logic [3:0]  mii_rxd_i,
   input wire logic        tx_en_i,
   input wire logic        speed_100_i,
   input wire logic        tx_cutoff_o,
   input wire logic        rx_wdt_expired_o,
   input wire logic        irq_o
);
   logic [31:0] ctl_q;
   logic [2:0]  ien_q;
   int          txc_q;
   int          lim;
   wire logic   wr = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i;
   // Cut-off limit in force for the current select bit and speed
   assign lim = ctl_q[BIT_JAB_SEL]
              ? int'(speed_100_i ? JAB_BT_100_CYCLES : JAB_BT_10_CYCLES)
              : int'(speed_100_i ? JAB_100_CYCLES : JAB_10_CYCLES);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl_q <= 32'h0000_0000;
         ien_q <= 3'h0;
         txc_q <= 0;
      end else begin
         if (wr && wb_adr_i[7:2] == ADR_WDT[7:2]) ctl_q <= wb_dat_i & WDT_RW;
         if (wr && wb_adr_i[7:2] == ADR_IRQ_EN[7:2]) ien_q <= wb_dat_i[2:0];
         txc_q <= tx_en_i ? txc_q + 1 : 0;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   property p_ack_resp;
      s_take |=> s_ack_pulse;
   endproperty
   a_ack_resp: assert property (p_ack_resp)
      else $error("ack missing or too long");
   property p_dat_zero;
      !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
   endproperty
   a_dat_zero: assert property (p_dat_zero)
      else $error("read data outside ack");
   property p_jab_min;
      $rose(tx_cutoff_o) |-> txc_q >= lim - 1 && txc_q <= lim + 3;
   endproperty
   a_jab_min: assert property (p_jab_min)
      else $error("cut-off at wrong time");
   property p_jab_cut;
      txc_q == lim + 5 && !ctl_q[BIT_JAB_DIS] |-> tx_cutoff_o;
   endproperty
   a_jab_cut: assert property (p_jab_cut)
      else $error("transmit not cut off");
   property p_jab_dis;
      ctl_q[BIT_JAB_DIS] && $past(ctl_q[BIT_JAB_DIS])
         && $past(ctl_q[BIT_JAB_DIS], 2) |-> !tx_cutoff_o;
   endproperty
   a_jab_dis: assert property (p_jab_dis)
      else $error("cut-off while disabled");
   property p_nj_hold;
      ctl_q[BIT_NO_REEN] && !ctl_q[BIT_JAB_DIS] && tx_cutoff_o && tx_en_i
         |=> tx_cutoff_o;
   endproperty
   a_nj_hold: assert property (p_nj_hold)
      else $error("cut-off dropped during transmit");
   property p_rwd;
      $rose(rx_wdt_expired_o) |-> !ctl_q[BIT_RW_DIS];
   endproperty
   a_rwd: assert property (p_rwd)
      else $error("watchdog expired while disabled");
   property p_irq_en;
      ien_q == 3'h0 && $past(ien_q) == 3'h0 && $past(ien_q, 2) == 3'h0
         |-> !irq_o;
   endproperty
   a_irq_en: assert property (p_irq_en)
      else $error("interrupt with all sources masked");
endmodule // wptw_properties

bind wptw_top wptw_properties #(
   .JAB_100_CYCLES(JAB_100_CYCLES), .JAB_10_CYCLES(JAB_10_CYCLES),
   .REEN_CYCLES(REEN_CYCLES), .JAB_BT_100_CYCLES(JAB_BT_100_CYCLES),
   .JAB_BT_10_CYCLES(JAB_BT_10_CYCLES)
) chk_u (
   .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
   .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .mii_rx_clk_i(mii_rx_clk_i),
   .mii_rx_dv_i(mii_rx_dv_i), .mii_rxd_i(mii_rxd_i), .tx_en_i(tx_en_i),
   .speed_100_i(speed_100_i), .tx_cutoff_o(tx_cutoff_o),
   .rx_wdt_expired_o(rx_wdt_expired_o), .irq_o(irq_o)
);

// ### bench/wptw_mii_model.sv
// MII receive source standing in for the line side
`timescale 1ns/1ps
module wptw_mii_model
   import wptw_pkg::*;
(
   output logic       mii_rx_clk_o,
   output logic       mii_rx_dv_o,
   output logic [3:0] mii_rxd_o
);
   initial begin
      mii_rx_clk_o = 1'b0;
      mii_rx_dv_o  = 1'b0;
      mii_rxd_o    = 4'h0;
   end
   // One clock period, data set up while the clock is low
   task automatic nib(input logic dv, input logic [3:0] d);
      mii_rx_dv_o = dv;
      mii_rxd_o   = d;
      #20 mii_rx_clk_o = 1'b1;
      #20 mii_rx_clk_o = 1'b0;
   endtask
   // Clock runs only for the frame and its idle tail
   task automatic send(input int unsigned n);
      repeat (15) nib(1'b1, 4'h5);
      nib(1'b1, SFD_NIB);
      for (int i = 0; i < 2 * n; i++) nib(1'b1, 4'(i));
      repeat (16) nib(1'b0, ~mii_rxd_o);
   endtask
endmodule // wptw_mii_model

// ### bench/tb_top.sv
// Register and pin-level test sequence of the wake pattern and watchdog block
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
   $display("unexpected at %0t: got %0h want %0h", $time, (a), (b)); end end
module tb_top
   import wptw_pkg::*;
;
   localparam int unsigned J100 = 50;
   localparam int unsigned J10  = 100;
   localparam int unsigned REEN = 80;
   localparam int unsigned B100 = 40;
   localparam int unsigned B10  = 60;
   logic        clk_i       = 1'b0;
   logic        rst_i       = 1'b1;
   logic [7:0]  wb_adr_i    = 8'h00;
   logic [31:0] wb_dat_i    = 32'h0000_0000;
   logic        wb_we_i     = 1'b0;
   logic [3:0]  wb_sel_i    = 4'h0;
   logic        wb_cyc_i    = 1'b0;
   logic        wb_stb_i    = 1'b0;
   logic        tx_en_i     = 1'b0;
   logic        speed_100_i = 1'b1;
   logic [31:0] wb_dat_o, rd;
   logic        wb_ack_o, mii_rx_clk_i, mii_rx_dv_i, tx_cutoff_o;
   logic        rx_wdt_expired_o, irq_o, seen;
   logic [3:0]  mii_rxd_i;
   int          fail_count = 0;
   int          cmp_count  = 0;
   int          n;
   int          lims[4] = '{J10, J100, B10, B100};
   always #5 clk_i = ~clk_i;
   wptw_top #(
      .JAB_100_CYCLES(J100), .JAB_10_CYCLES(J10), .REEN_CYCLES(REEN),
      .JAB_BT_100_CYCLES(B100), .JAB_BT_10_CYCLES(B10)
   ) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
      .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_ack_o(wb_ack_o), .mii_rx_clk_i(mii_rx_clk_i),
      .mii_rx_dv_i(mii_rx_dv_i), .mii_rxd_i(mii_rxd_i), .tx_en_i(tx_en_i),
      .speed_100_i(speed_100_i), .tx_cutoff_o(tx_cutoff_o),
      .rx_wdt_expired_o(rx_wdt_expired_o), .irq_o(irq_o)
   );
   wptw_mii_model mii_u (.mii_rx_clk_o(mii_rx_clk_i),
      .mii_rx_dv_o(mii_rx_dv_i), .mii_rxd_o(mii_rxd_i));
   task automatic print_verdict();
      if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
      int k;
      k = 0;
      wb_adr_i <= a;
      wb_we_i  <= w;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 20);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (wb_ack_o !== 1'b1) begin
         fail_count++;
         print_verdict();
      end
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d, rd);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      bus(a, 1'b0, 32'h0000_0000, rd);
      `CHK(rd, e)
   endtask
   task automatic wait_cut(input logic v, output int c);
      c = 0;
      while (tx_cutoff_o !== v && c < 2000) begin
         @(posedge clk_i);
         c++;
      end
      if (c >= 2000) begin
         fail_count++;
         print_verdict();
      end
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rc(ADR_WDT, WDT_RST);
      wr(ADR_WDT, 32'hFFFF_FFFF);
      rc(ADR_WDT, WDT_RW);
      wr(ADR_MATCH_EN, 32'hFFFF_FFFF);
      rc(ADR_MATCH_EN, 32'h0000_001F);
      wr(8'h40, 32'hFFFF_FFFF);
      rc(8'h40, 32'h0000_0000);
      rc(ADR_PATTERN, 32'h0000_0000);
      for (int i = 0; i < 25; i++) begin
         wr(ADR_PATTERN, 32'h0000_0000 + i);
         if (i == 2 || i == 24) begin
            bus(ADR_STATUS, 1'b0, 32'h0000_0000, rd);
            `CHK(rd[12:8], (i == 2) ? 5'h03 : 5'h00)
         end
      end
      repeat (3) wr(ADR_PATTERN, 32'h0000_00FF);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rc(ADR_STATUS, 32'h0000_0000);
      wr(ADR_IRQ_EN, 32'h0000_0004);
      rc(ADR_IRQ_EN, 32'h0000_0004);
      for (int m = 0; m < 4; m++) begin
         wr(ADR_WDT, m[1] ? 32'h0000_0004 : 32'h0000_0000);
         speed_100_i <= m[0];
         tx_en_i <= 1'b1;
         @(posedge clk_i);
         wait_cut(1'b1, n);
         `CHK(n >= lims[m] && n <= lims[m] + 3, 1'b1)
         tx_en_i <= 1'b0;
         wait_cut(1'b0, n);
         `CHK(n + 3 >= REEN && n <= REEN + 3, 1'b1)
      end
      `CHK(irq_o, 1'b1)
      wr(ADR_IRQ_CLR, 32'h0000_0004);
      repeat (2) @(posedge clk_i);
      `CHK(irq_o, 1'b0)
      wr(ADR_IRQ_EN, 32'h0000_0000);
      wr(ADR_WDT, 32'h0000_0002);
      tx_en_i <= 1'b1;
      repeat (J100 + REEN + 50) @(posedge clk_i);
      `CHK(tx_cutoff_o, 1'b1)
      `CHK(irq_o, 1'b0)
      tx_en_i <= 1'b0;
      wait_cut(1'b0, n);
      `CHK(n <= 3, 1'b1)
      wr(ADR_WDT, 32'h0000_0001);
      tx_en_i <= 1'b1;
      repeat (300) @(posedge clk_i);
      `CHK(tx_cutoff_o, 1'b0)
      tx_en_i <= 1'b0;
      wr(ADR_IRQ_CLR, 32'h0000_0007);
      repeat (4) wr(ADR_PATTERN, 32'h0000_0000);
      wr(ADR_PATTERN, 32'hFFFF_0000);
      for (int k = 0; k < 3; k++) begin
         wr(ADR_WDT, k == 1 ? 32'h1000_0010
                            : 32'h0000_0000 + 16 * k);
         wr(ADR_MATCH_EN, k);
         seen = 1'b0;
         fork
            mii_u.send(k == 0 ? 2560 : 2561);
            repeat (21000) begin
               @(posedge clk_i);
               if (rx_wdt_expired_o === 1'b1) seen = 1'b1;
            end
         join
         `CHK(seen, k == 2)
         `CHK(rx_wdt_expired_o, 1'b0)
         bus(ADR_STATUS, 1'b0, 32'h0000_0000, rd);
         `CHK(rd[ST_RX_WDT], k == 2)
         `CHK(rd[ST_WAKE], k == 1)
         wr(ADR_IRQ_CLR, 32'h0000_0001);
      end
      wr(ADR_IRQ_CLR, 32'h0000_0002);
      bus(ADR_STATUS, 1'b0, 32'h0000_0000, rd);
      `CHK(rd[ST_RX_WDT], 1'b0)
      print_verdict();
   end
endmodule // tb_top
